// *** lpt_rx_pkg.sv ***
package lpt_rx_pkg;
    // Clock rate and handshake timing
    localparam int CLK_HZ = 20_000_000;
    localparam int ACK_NS = 1000; // Acknowledge pulse width in ns
    localparam logic [7:0] ACK_CYC = 8'((ACK_NS * (CLK_HZ / 1_000_000) + 999) / 1000);

    // Receive buffer geometry
    localparam int MEM_AW = 20;
    localparam int CNT_W = 21;

    // Register byte offsets
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_STAT = 5'h04;
    localparam logic [4:0] REG_DATA = 5'h08;
    localparam logic [4:0] REG_IRQ = 5'h0C;
    localparam logic [4:0] REG_MASK = 5'h10;
    localparam logic [4:0] REG_TX = 5'h14;

    // Control register field positions
    localparam int CTL_ONLINE = 0;
    localparam int CTL_PRIME_EN = 1;
    localparam int CTL_PAPER_OUT = 2;
    localparam int CTL_ALARM = 3;
    localparam int CTL_ENG_BUSY = 4;
    localparam int CTL_MODE = 5;
    localparam int CTL_SIZE = 8;

    // Reset values
    localparam logic [2:0] SIZE_RST = 3'h0;
    localparam logic [5:0] MASK_RST = 6'h00;

    // Interrupt event bit positions
    localparam int EV_RX = 0;
    localparam int EV_FULL = 1;
    localparam int EV_PRIME = 2;
    localparam int EV_MODE = 3;
    localparam int EV_NIB = 4;
    localparam int EV_OVR = 5;
    localparam int EV_N = 6;

    // Buffer capacity per size code
    localparam logic [20:0] CAP_8K = 21'h002000;
    localparam logic [20:0] CAP_20K = 21'h005000;
    localparam logic [20:0] CAP_50K = 21'h00C800;
    localparam logic [20:0] CAP_100K = 21'h019000;
    localparam logic [20:0] CAP_1M = 21'h100000;

    typedef enum logic [1:0] {
        MODE_COMPAT = 2'b00,
        MODE_NIBBLE = 2'b01,
        MODE_ECP = 2'b10
    } mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ACK = 3'b001,
        ST_ECP_WAIT = 3'b010,
        ST_NIB = 3'b011
    } state_t;
endpackage

// *** printer_parallel_receiver.sv ***
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// Behaviour
// [RQ1] Host drives eight data bits; device samples them on the strobe's falling edge.
// [RQ2] Acknowledge pulses after a byte is taken or a nibble handed over. ECP bytes get no ack_n pulse; only busy answers the strobe.
// [RQ3] Busy stays high during processing of a transfer and during any alarm. While entering or in ST_NIB, busy carries nibble bit 3 instead.
// [RQ4] Fault is asserted on paper out or alarm; paper end follows paper out. While entering or in ST_NIB, both pins carry nibble bits instead.
// [RQ5] Auto feed low with select in high is taken as a mode-change request.
// [RQ6] Compatibility, nibble and ECP modes each run their own handshake.
// [RQ7] Transfer unit is 8 bits compatibility, 4 bits nibble, 9 bits ECP.
// [RQ8] Receive buffer capacity selectable as 8K, 20K, 50K, 100K or 1M bytes.
// [RQ9] Every accepted byte enters the receive buffer in arrival order.
// [RQ10] Busy refuses further host transfers while data cannot be accepted.
// [RQ11] Handshake follows the currently active mode and switches with it.
// [RQ12] Status outputs are actively driven from the current state.
// [RQ13] With prime enabled, init low resets the port; otherwise init is ignored.
// [RQ14] Select is high while on-line, low while off-line. While entering or in ST_NIB, select carries nibble bit 1, even off-line.
module printer_parallel_receiver (
    input wire logic clk, // 20 MHz clock
    input wire logic reset, // Synchronous, active high
    input wire logic [4:0] addr, // Register byte address
    input wire logic [31:0] wdata, // Register write data
    input wire logic wr_en, // Write strobe
    input wire logic rd_en, // Read strobe
    output logic [31:0] rdata, // Read data, cycle after rd_en
    output logic irq, // Level interrupt
    input wire logic [7:0] data_in, // Host data lines
    input wire logic strobe_n, // Host data strobe
    input wire logic init_n, // Host initialisation
    input wire logic autofd_n, // Host auto feed / mode request
    input wire logic selin_n, // Host select in / mode request
    output logic ack_n, // Acknowledge to host
    output logic busy, // Busy to host
    output logic paper_end, // Paper end to host
    output logic select, // Select to host
    output logic fault_n // Fault to host
);
    import lpt_rx_pkg::*;

    logic online_ff, prime_en_ff, paper_out_ff, alarm_ff, eng_busy_ff;
    mode_t mode_ff;
    logic [2:0] size_ff;
    logic [EV_N-1:0] mask_ff, irq_st_ff, nxt_irq_st, ev;
    logic [7:0] tx_ff;
    logic tx_vld_ff, nib_hi_ff;
    logic stb_q_ff, afd_q_ff, init_q_ff, req_q_ff;
    state_t state_ff, nxt_state;
    logic [7:0] cnt_ff, nxt_cnt;
    logic [8:0] rx_mem [0:(1 << MEM_AW) - 1];
    logic [MEM_AW-1:0] wp_ff, rp_ff;
    logic [CNT_W-1:0] count_ff, cap;
    logic [3:0] nib;
    logic [31:0] ctrl_rd;
    logic stb_fall, stb_rise, afd_fall, init_fall, prime_act, req;
    logic full, refuse, accept, pop, nib_done, overrun, wr_ctrl;

    // Host line edges; pins are synchronous so one sample suffices
    assign stb_fall = stb_q_ff & ~strobe_n;
    assign stb_rise = ~stb_q_ff & strobe_n;
    assign afd_fall = afd_q_ff & ~autofd_n;
    assign init_fall = init_q_ff & ~init_n;
    assign prime_act = init_fall & prime_en_ff; // [RQ13]
    assign req = selin_n & ~autofd_n; // [RQ5]
    assign wr_ctrl = wr_en && (addr == REG_CTRL);

    always_ff @(posedge clk) begin
        if (reset) begin
            stb_q_ff <= 1'b1;
            afd_q_ff <= 1'b1;
            init_q_ff <= 1'b1;
            req_q_ff <= 1'b0;
        end else begin
            stb_q_ff <= strobe_n;
            afd_q_ff <= autofd_n;
            init_q_ff <= init_n;
            req_q_ff <= req;
        end
    end

    // Capacity limit; storage is sized for the largest setting
    always_comb begin
        case (size_ff)
            3'h0: cap = CAP_8K; // [RQ8]
            3'h1: cap = CAP_20K;
            3'h2: cap = CAP_50K;
            3'h3: cap = CAP_100K;
            default: cap = CAP_1M;
        endcase
    end

    assign full = (count_ff >= cap);
    assign refuse = full | eng_busy_ff | alarm_ff | ~online_ff; // [RQ10]
    assign accept = (state_ff == ST_IDLE) && stb_fall && (mode_ff != MODE_NIBBLE)
        && !refuse && !busy; // [RQ1] [RQ10]
    assign overrun = stb_fall && !accept && (mode_ff != MODE_NIBBLE);
    assign pop = rd_en && (addr == REG_DATA) && (count_ff != '0);
    assign nib_done = (state_ff == ST_NIB) && autofd_n && nib_hi_ff;
    assign nib = nib_hi_ff ? tx_ff[7:4] : tx_ff[3:0]; // [RQ7]

    // Handshake sequencer; a mode change is picked up only between transfers
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            ST_IDLE: begin
                if (accept) begin
                    nxt_state = (mode_ff == MODE_ECP) ? ST_ECP_WAIT : ST_ACK; // [RQ6] [RQ11]
                    nxt_cnt = ACK_CYC;
                end else if ((mode_ff == MODE_NIBBLE) && afd_fall && tx_vld_ff) begin
                    nxt_state = ST_NIB; // [RQ6]
                end
            end
            ST_ACK: begin
                if (cnt_ff != 8'h00) begin
                    nxt_cnt = cnt_ff - 8'h01;
                end else if (strobe_n) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_ECP_WAIT: begin
                if (stb_rise) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_NIB: begin
                if (autofd_n) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
        if (prime_act) begin
            nxt_state = ST_IDLE; // [RQ13]
            nxt_cnt = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // Receive storage; ECP keeps the command flag as the ninth bit
    always_ff @(posedge clk) begin
        if (accept) begin
            rx_mem[wp_ff] <= {(mode_ff == MODE_ECP) & ~autofd_n, data_in}; // [RQ7] [RQ9]
        end
    end

    always_ff @(posedge clk) begin
        if (reset || prime_act) begin
            wp_ff <= '0;
            rp_ff <= '0;
            count_ff <= '0; // [RQ13]
        end else begin
            if (accept) begin
                wp_ff <= wp_ff + 1'b1; // [RQ9]
            end
            if (pop) begin
                rp_ff <= rp_ff + 1'b1;
            end
            case ({accept, pop})
                2'b10: count_ff <= count_ff + 21'h1;
                2'b01: count_ff <= count_ff - 21'h1;
                default: count_ff <= count_ff;
            endcase
        end
    end

    // Host status pins; nibble data rides the status lines during reverse transfer
    always_ff @(posedge clk) begin
        if (reset) begin
            ack_n <= 1'b1;
            busy <= 1'b1;
            paper_end <= 1'b0;
            select <= 1'b0;
            fault_n <= 1'b1;
        end else if (nxt_state == ST_NIB) begin
            ack_n <= 1'b0; // [RQ2] [RQ6]
            busy <= nib[3]; // [RQ7]
            paper_end <= nib[2];
            select <= nib[1];
            fault_n <= nib[0];
        end else begin
            ack_n <= !((nxt_state == ST_ACK) && (nxt_cnt != 8'h00)); // [RQ2]
            busy <= refuse || (nxt_state != ST_IDLE); // [RQ3] [RQ10] [RQ12]
            paper_end <= paper_out_ff; // [RQ4]
            select <= online_ff; // [RQ14]
            fault_n <= !(paper_out_ff || alarm_ff); // [RQ4]
        end
    end

    // Nibble source byte; low nibble goes first, a new write wins over completion
    always_ff @(posedge clk) begin
        if (reset || prime_act) begin
            tx_ff <= 8'h00;
            tx_vld_ff <= 1'b0;
            nib_hi_ff <= 1'b0;
        end else if (wr_en && (addr == REG_TX)) begin
            tx_ff <= wdata[7:0];
            tx_vld_ff <= 1'b1;
            nib_hi_ff <= 1'b0;
        end else if ((state_ff == ST_NIB) && autofd_n) begin
            nib_hi_ff <= ~nib_hi_ff;
            if (nib_hi_ff) begin
                tx_vld_ff <= 1'b0;
            end
        end
    end

    // Control register
    always_ff @(posedge clk) begin
        if (reset) begin
            online_ff <= 1'b1;
            prime_en_ff <= 1'b1;
            paper_out_ff <= 1'b0;
            alarm_ff <= 1'b0;
            eng_busy_ff <= 1'b0;
            mode_ff <= MODE_COMPAT;
            size_ff <= SIZE_RST;
        end else if (wr_ctrl) begin
            online_ff <= wdata[CTL_ONLINE];
            prime_en_ff <= wdata[CTL_PRIME_EN];
            paper_out_ff <= wdata[CTL_PAPER_OUT];
            alarm_ff <= wdata[CTL_ALARM];
            eng_busy_ff <= wdata[CTL_ENG_BUSY];
            mode_ff <= mode_t'(wdata[CTL_MODE +: 2]);
            size_ff <= wdata[CTL_SIZE +: 3];
        end
    end

    // Events; mode requests are only meaningful while in compatibility mode
    always_comb begin
        ev = '0;
        ev[EV_RX] = accept;
        ev[EV_FULL] = accept && (count_ff + 21'h1 == cap);
        ev[EV_PRIME] = prime_act;
        ev[EV_MODE] = req && !req_q_ff && (mode_ff == MODE_COMPAT); // [RQ5]
        ev[EV_NIB] = nib_done;
        ev[EV_OVR] = overrun;
        nxt_irq_st = irq_st_ff;
        if (wr_en && (addr == REG_IRQ)) begin
            nxt_irq_st = irq_st_ff & ~wdata[EV_N-1:0];
        end
        nxt_irq_st = nxt_irq_st | ev; // Set wins over clear
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_st_ff <= '0;
            mask_ff <= MASK_RST;
            irq <= 1'b0;
        end else begin
            irq_st_ff <= nxt_irq_st;
            if (wr_en && (addr == REG_MASK)) begin
                mask_ff <= wdata[EV_N-1:0];
            end
            irq <= |(nxt_irq_st & mask_ff);
        end
    end

    always_comb begin
        ctrl_rd = '0;
        ctrl_rd[CTL_ONLINE] = online_ff;
        ctrl_rd[CTL_PRIME_EN] = prime_en_ff;
        ctrl_rd[CTL_PAPER_OUT] = paper_out_ff;
        ctrl_rd[CTL_ALARM] = alarm_ff;
        ctrl_rd[CTL_ENG_BUSY] = eng_busy_ff;
        ctrl_rd[CTL_MODE +: 2] = mode_ff;
        ctrl_rd[CTL_SIZE +: 3] = size_ff;
    end

    // Read port; data stands for exactly one cycle, unmapped reads give zero
    always_ff @(posedge clk) begin
        if (reset || !rd_en) begin
            rdata <= 32'h0;
        end else if (addr == REG_CTRL) begin
            rdata <= ctrl_rd;
        end else if (addr == REG_STAT) begin
            rdata <= {3'h0, tx_vld_ff, state_ff, full, 3'h0, count_ff};
        end else if (addr == REG_DATA) begin
            rdata <= (count_ff != '0) ? {23'h0, rx_mem[rp_ff]} : 32'h0;
        end else if (addr == REG_IRQ) begin
            rdata <= {26'h0, irq_st_ff};
        end else if (addr == REG_MASK) begin
            rdata <= {26'h0, mask_ff};
        end else if (addr == REG_TX) begin
            rdata <= {24'h0, tx_ff};
        end else begin
            rdata <= 32'h0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sample_data_a: assert property (accept |=> rx_mem[$past(wp_ff)][7:0] == $past(data_in)) // [RQ1]
        else $error("strobed byte not stored");
    ack_pulse_a: assert property (accept && mode_ff == MODE_COMPAT |=> (!ack_n)[*8]) // [RQ2]
        else $error("acknowledge pulse too short");
    alarm_busy_a: assert property (alarm_ff && nxt_state != ST_NIB |=> busy) // [RQ3]
        else $error("busy low during alarm");
    paper_fault_a: assert property (paper_out_ff && nxt_state != ST_NIB |=> !fault_n && paper_end) // [RQ4]
        else $error("paper out not signalled");
    mode_req_a: assert property (mode_ff == MODE_COMPAT && $rose(req) |=> irq_st_ff[EV_MODE]) // [RQ5]
        else $error("mode request lost");
    nib_pins_a: assert property (state_ff == ST_NIB |-> !ack_n && busy == nib[3]) // [RQ6]
        else $error("nibble lines wrong");
    compat_width_a: assert property (accept && mode_ff == MODE_COMPAT |=> !rx_mem[$past(wp_ff)][8]) // [RQ7]
        else $error("compat byte flagged as command");
    cap_limit_a: assert property (accept |=> count_ff <= $past(cap)) // [RQ8]
        else $error("buffer exceeds capacity");
    count_step_a: assert property (accept && !pop |=> count_ff == $past(count_ff) + 21'h1) // [RQ9]
        else $error("buffer count not advanced");
    full_busy_a: assert property (full && nxt_state != ST_NIB |=> busy) // [RQ10]
        else $error("busy low while full");
    ecp_release_a: assert property (state_ff == ST_ECP_WAIT && stb_rise |=> busy == $past(refuse)) // [RQ11]
        else $error("ECP busy not released");
    prime_reset_a: assert property (prime_act |=> count_ff == '0 && state_ff == ST_IDLE) // [RQ13]
        else $error("prime did not clear");
    prime_off_a: assert property (init_fall && !prime_en_ff && !pop |=> count_ff >= $past(count_ff)) // [RQ13]
        else $error("init acted while prime disabled");
    offline_sel_a: assert property (!online_ff && nxt_state != ST_NIB |=> !select && busy) // [RQ14] [RQ12]
        else $error("select high while off-line");

    compat_rx_c: cover property (accept && mode_ff == MODE_COMPAT ##1 state_ff == ST_ACK);
    ecp_rx_c: cover property (accept && mode_ff == MODE_ECP && !autofd_n);
    nib_done_c: cover property (nib_done);
    prime_c: cover property (prime_act && count_ff != '0);
endmodule // printer_parallel_receiver

// *** lpt_host_model.sv ***
`timescale 1ns/1ps
// Host side of the parallel link, driven through its tasks by the bench
module lpt_host_model (
    input wire logic clk, // Bench clock
    input wire logic ack_n, // Acknowledge from device
    input wire logic busy, // Busy from device
    input wire logic paper_end, // Paper end from device
    input wire logic select, // Select from device
    input wire logic fault_n, // Fault from device
    output logic [7:0] data_in, // Data lines
    output logic strobe_n, // Data strobe
    output logic init_n, // Initialise
    output logic autofd_n, // Auto feed, command flag, host ready
    output logic selin_n // Select in
);
    // Idle levels at time zero
    initial begin
        data_in = 8'h00;
        strobe_n = 1'b1;
        init_n = 1'b1;
        autofd_n = 1'b1;
        selin_n = 1'b0;
    end

    // One strobed unit; released data lines show the inverse so stale data never matches
    task automatic send(input logic [7:0] d, input logic cmd, output int acks);
        acks = 0;
        @(posedge clk);
        data_in <= d;
        autofd_n <= ~cmd;
        strobe_n <= 1'b0;
        for (int i = 0; i < 80; i++) begin
            @(posedge clk);
            if (i == 3) begin
                strobe_n <= 1'b1;
                data_in <= ~d;
                autofd_n <= 1'b1;
            end
            #1;
            if (ack_n === 1'b0) acks++;
            if (i > 4 && busy === 1'b0) break;
        end
    endtask

    // One reverse nibble, read from the status pins while acknowledge is low
    task automatic nib(output logic [3:0] n);
        @(posedge clk);
        autofd_n <= 1'b0;
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            #1;
            if (ack_n === 1'b0) break;
        end
        n = {busy, paper_end, select, fault_n};
        @(posedge clk);
        autofd_n <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            #1;
            if (ack_n === 1'b1) break;
        end
    endtask

    // Mode change request on auto feed and select in
    task automatic mode_req();
        @(posedge clk);
        selin_n <= 1'b1;
        autofd_n <= 1'b0;
        repeat (3) @(posedge clk);
        autofd_n <= 1'b1;
        selin_n <= 1'b0;
    endtask

    // Initialise pulse
    task automatic prime();
        @(posedge clk);
        init_n <= 1'b0;
        repeat (3) @(posedge clk);
        init_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
endmodule // lpt_host_model

// *** test_printer_parallel_receiver.sv ***
`timescale 1ns/1ps
module test_printer_parallel_receiver;
    import lpt_rx_pkg::*;
    logic clk, reset, wr_en, rd_en, irq, ack_n, busy, paper_end, select, fault_n;
    logic strobe_n, init_n, autofd_n, selin_n;
    logic [4:0] addr;
    logic [31:0] wdata, rdata, d;
    logic [7:0] data_in;
    logic [3:0] n;
    int err_count, num_checks, acks;

    printer_parallel_receiver i_printer_parallel_receiver (.clk(clk), .reset(reset),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq),
        .data_in(data_in), .strobe_n(strobe_n), .init_n(init_n), .autofd_n(autofd_n),
        .selin_n(selin_n), .ack_n(ack_n), .busy(busy), .paper_end(paper_end),
        .select(select), .fault_n(fault_n));
    lpt_host_model i_lpt_host_model (.clk(clk), .ack_n(ack_n), .busy(busy),
        .paper_end(paper_end), .select(select), .fault_n(fault_n), .data_in(data_in),
        .strobe_n(strobe_n), .init_n(init_n), .autofd_n(autofd_n), .selin_n(selin_n));

    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Bus accesses: strobes one cycle long, read data taken in the following cycle
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Whole run is a few hundred cycles; this bound only catches a hang
    initial begin
        #1_000_000;
        err_count++;
        close_out();
    end

    initial begin
        err_count = 0;
        num_checks = 0;
        reset = 1'b1;
        addr = 5'h00;
        wdata = 32'h00000000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("status pins", {27'h0, ack_n, busy, paper_end, select, fault_n}, 32'h13);
        rd(REG_CTRL, d);
        chk("ctrl reset", d, 32'h00000003);
        rd(REG_MASK, d);
        chk("mask reset", d, 32'h00000000);
        rd(5'h18, d);
        chk("unmapped", d, 32'h00000000);
        i_lpt_host_model.mode_req();
        rd(REG_IRQ, d);
        chk("mode request", {31'h0, d[EV_MODE]}, 32'h1);
        // Three bytes back to back, each acknowledged for the full pulse width
        for (int k = 0; k < 3; k++) begin
            i_lpt_host_model.send(8'h11 << k, 1'b0, acks);
            chk("ack width", 32'(acks), 32'(ACK_CYC));
        end
        rd(REG_STAT, d);
        chk("count", d & 32'h001FFFFF, 32'h00000003);
        for (int k = 0; k < 3; k++) begin
            rd(REG_DATA, d);
            chk("fifo order", d, 32'(8'h11 << k));
        end
        // Interrupt raised by an unmasked event, then cleared
        wr(REG_MASK, 32'h00000001);
        repeat (2) @(posedge clk);
        #1;
        chk("irq set", {31'h0, irq}, 32'h1);
        wr(REG_IRQ, 32'h0000003F);
        repeat (2) @(posedge clk);
        #1;
        chk("irq clear", {31'h0, irq}, 32'h0);
        wr(REG_MASK, 32'h00000000);
        // Paper out: fault and paper end; paper out alone does not refuse input
        wr(REG_CTRL, 32'h00000007);
        repeat (2) @(posedge clk);
        #1;
        chk("paper out", {29'h0, busy, paper_end, fault_n}, 32'h2);
        // Alarm: busy and fault; a strobe now is refused
        wr(REG_CTRL, 32'h0000000B);
        repeat (2) @(posedge clk);
        #1;
        chk("alarm", {29'h0, busy, paper_end, fault_n}, 32'h4);
        i_lpt_host_model.send(8'h77, 1'b0, acks);
        chk("refused ack", 32'(acks), 32'h0);
        rd(REG_IRQ, d);
        chk("overrun", {31'h0, d[EV_OVR]}, 32'h1);
        rd(REG_STAT, d);
        chk("refused count", d & 32'h001FFFFF, 32'h00000000);
        wr(REG_CTRL, 32'h00000002);
        repeat (2) @(posedge clk);
        #1;
        chk("offline", {30'h0, busy, select}, 32'h2);
        // ECP forward: nine-bit units, no acknowledge pulse
        wr(REG_CTRL, 32'h00000043);
        i_lpt_host_model.send(8'h5A, 1'b1, acks);
        chk("ecp ack", 32'(acks), 32'h0);
        i_lpt_host_model.send(8'hC3, 1'b0, acks);
        rd(REG_DATA, d);
        chk("ecp command", d, 32'h0000015A);
        rd(REG_DATA, d);
        chk("ecp data", d, 32'h000000C3);
        // Nibble reverse: low nibble first on the status pins
        wr(REG_CTRL, 32'h00000023);
        wr(REG_TX, 32'h000000A5);
        wr(REG_IRQ, 32'h0000003F);
        i_lpt_host_model.nib(n);
        chk("nibble low", {28'h0, n}, 32'h5);
        i_lpt_host_model.nib(n);
        chk("nibble high", {28'h0, n}, 32'hA);
        rd(REG_IRQ, d);
        chk("nibble done", {31'h0, d[EV_NIB]}, 32'h1);
        // Initialise clears reception only while prime is enabled
        wr(REG_CTRL, 32'h00000003);
        i_lpt_host_model.send(8'h3C, 1'b0, acks);
        i_lpt_host_model.prime();
        rd(REG_STAT, d);
        chk("prime clears", d & 32'h001FFFFF, 32'h00000000);
        rd(REG_IRQ, d);
        chk("prime event", {31'h0, d[EV_PRIME]}, 32'h1);
        wr(REG_CTRL, 32'h00000001);
        i_lpt_host_model.send(8'h3C, 1'b0, acks);
        i_lpt_host_model.prime();
        rd(REG_STAT, d);
        chk("prime ignored", d & 32'h001FFFFF, 32'h00000001);
        rd(REG_DATA, d);
        chk("kept byte", d, 32'h0000003C);
        // Size codes 0 to 4 are accepted and read back
        for (int s = 0; s < 5; s++) begin
            wr(REG_CTRL, 32'h00000003 | (32'(s) << CTL_SIZE));
            rd(REG_CTRL, d);
            chk("size code", d, 32'h00000003 | (32'(s) << CTL_SIZE));
        end
        close_out();
    end
endmodule // test_printer_parallel_receiver
